/* include/tmr3_pkg.sv */
// Package: register map, field positions and timing constants for timer 3
package tmr3_pkg;
  // Special-function register bus
  localparam logic [7:0] TMR3_ADDR_CTRL   = 8'h91;
  localparam logic [7:0] TMR3_ADDR_RELL   = 8'h92;
  localparam logic [7:0] TMR3_ADDR_RELH   = 8'h93;
  localparam logic [7:0] TMR3_ADDR_CNTL   = 8'h94;
  localparam logic [7:0] TMR3_ADDR_CNTH   = 8'h95;
  localparam logic [3:0] TMR3_SFR_PAGE    = 4'h0;
  localparam logic [7:0] TMR3_CTRL_RESET  = 8'h00;
  localparam logic [7:0] TMR3_BYTE_RESET  = 8'h00;
  localparam logic [7:0] TMR3_BYTE_MAX    = 8'hFF;
  // Control register bit positions
  localparam int TMR3_BIT_HFLAG  = 7;
  localparam int TMR3_BIT_LFLAG  = 6;
  localparam int TMR3_BIT_LIEN   = 5;
  localparam int TMR3_BIT_CAPEN  = 4;
  localparam int TMR3_BIT_SPLIT  = 3;
  localparam int TMR3_BIT_RUN    = 2;
  localparam int TMR3_BIT_XCLK1  = 1;
  localparam int TMR3_BIT_XCLK0  = 0;
  // External clock select encodings
  localparam logic [1:0] TMR3_XCLK_DIV12_CMP = 2'h0;
  localparam logic [1:0] TMR3_XCLK_OSC8_CMP  = 2'h1;
  localparam logic [1:0] TMR3_XCLK_DIV12_OSC = 2'h2;
  localparam logic [1:0] TMR3_XCLK_CMP_OSC   = 2'h3;
  // Dividers
  localparam logic [3:0] TMR3_DIV12_LAST = 4'hB;
  localparam logic [2:0] TMR3_DIV8_LAST  = 3'h7;
endpackage

/* logic/tmr3_edge_div.sv */
// Synchroniser, rising edge detector and optional divide by eight
`timescale 1ns/10ps
`default_nettype none
module tmr3_edge_div
  import tmr3_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic src_in,
  output logic      edge_pulse,
  output logic      div8_pulse
);
  logic       sync_a;
  logic       sync_b;
  logic       sync_c;
  logic [2:0] cnt;
  logic       next_sync_a;
  logic       next_sync_b;
  logic       next_sync_c;
  logic [2:0] next_cnt;
  logic       next_edge;
  logic       next_div8;

  // Next state: sync chain, edge and every eighth edge
  always_comb begin
    next_sync_a = src_in;
    next_sync_b = sync_a;
    next_sync_c = sync_b;
    next_edge   = sync_b & ~sync_c;
    next_cnt    = cnt;
    next_div8   = 1'b0;
    if (next_edge) begin
      next_cnt = cnt + 3'h1;
      next_div8 = (cnt == TMR3_DIV8_LAST);
    end
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync_a     <= 1'b0;
      sync_b     <= 1'b0;
      sync_c     <= 1'b0;
      cnt        <= 3'h0;
      edge_pulse <= 1'b0;
      div8_pulse <= 1'b0;
    end else begin
      sync_a     <= next_sync_a;
      sync_b     <= next_sync_b;
      sync_c     <= next_sync_c;
      cnt        <= next_cnt;
      edge_pulse <= next_edge;
      div8_pulse <= next_div8;
    end
  end
endmodule
`default_nettype wire

/* logic/tmr3_timer.sv */
// Timer 3: control/status register, counter, reload and capture logic
// Notes on behaviour
// - The high flag sets whenever the upper count byte wraps from FF to its reload value.
// - In 16-bit mode the high flag sets when the whole count wraps from FFFF to the reload value.
// - With the timer interrupt enabled, a set high flag requests service.
// - Neither flag clears by itself; only a software write of 0 clears it.
// - The low flag sets on every low byte wrap, in every mode.
// - With low enable and timer interrupt enabled, low wraps interrupt.
// - A one in the capture enable bit selects capture mode.
// - Control register at page 0 address 91h, bits laid out, reset zero.
// - Split clear gives one 16-bit reload counter, set gives two 8-bit.
// - Run enables counting; in split mode it gates only the upper byte.
// - Clock select picks external clock and capture trigger, synced.
// - With capture enabled, a capture trigger copies the count to reload and sets the high flag.
`timescale 1ns/10ps
`default_nettype none
module tmr3_timer
  import tmr3_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [3:0] sfr_page,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  output logic [7:0]      sfr_rdata,
  input  wire logic       clk_sel_high,
  input  wire logic       clk_sel_low,
  input  wire logic       timer_irq_enable,
  input  wire logic       ext_osc_in,
  input  wire logic       comparator_in,
  output logic            timer_irq
);
  logic [7:0] ctrl;
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [7:0] reload_low_byte;
  logic [7:0] reload_high_byte;
  logic [3:0] div12_cnt;
  logic [7:0] next_ctrl;
  logic [7:0] next_cnt_lo;
  logic [7:0] next_cnt_hi;
  logic [7:0] next_rel_lo;
  logic [7:0] next_rel_hi;
  logic [3:0] next_div12;
  logic [7:0] next_rdata;
  logic       div12_tick;
  logic       cmp_edge;
  logic       osc_div8;
  logic       ext_tick;
  logic       cap_trig;
  logic       tick_lo;
  logic       tick_hi;
  logic       wrap_lo;
  logic       wrap_hi;
  logic       split_mode_select;
  logic       run_control;
  logic       capture_mode_enable;
  logic [1:0] ext_clock_select;

  // Address decode helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (sfr_page == TMR3_SFR_PAGE) && (a == r);
  endfunction

  assign split_mode_select   = ctrl[TMR3_BIT_SPLIT];
  assign run_control         = ctrl[TMR3_BIT_RUN];
  assign capture_mode_enable = ctrl[TMR3_BIT_CAPEN];
  assign ext_clock_select    = ctrl[TMR3_BIT_XCLK1:TMR3_BIT_XCLK0];

  // Synchronised external sources
  tmr3_edge_div u_osc (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .src_in     (ext_osc_in),
    .edge_pulse (),
    .div8_pulse (osc_div8)
  );
  tmr3_edge_div u_cmp (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .src_in     (comparator_in),
    .edge_pulse (cmp_edge),
    .div8_pulse ()
  );

  // External clock and capture trigger selection
  always_comb begin
    div12_tick = (div12_cnt == TMR3_DIV12_LAST);
    case (ext_clock_select)
      TMR3_XCLK_DIV12_CMP: begin
        ext_tick = div12_tick;
        cap_trig = cmp_edge;
      end
      TMR3_XCLK_OSC8_CMP: begin
        ext_tick = osc_div8;
        cap_trig = cmp_edge;
      end
      TMR3_XCLK_DIV12_OSC: begin
        ext_tick = div12_tick;
        cap_trig = osc_div8;
      end
      default: begin
        ext_tick = cmp_edge;
        cap_trig = osc_div8;
      end
    endcase
  end

  // Per-byte count enables and wraps
  always_comb begin
    tick_lo = clk_sel_low ? 1'b1 : ext_tick;
    tick_hi = clk_sel_high ? 1'b1 : ext_tick;
    wrap_lo = 1'b0;
    wrap_hi = 1'b0;
    if (split_mode_select) begin
      wrap_lo = tick_lo && (count_low_byte == TMR3_BYTE_MAX);
      wrap_hi = run_control && tick_hi
                && (count_high_byte == TMR3_BYTE_MAX);
    end else if (run_control) begin
      wrap_lo = tick_lo && (count_low_byte == TMR3_BYTE_MAX);
      wrap_hi = wrap_lo && (count_high_byte == TMR3_BYTE_MAX);
    end
  end

  // Counter, reload, divider and control next state
  always_comb begin
    next_cnt_lo = count_low_byte;
    next_cnt_hi = count_high_byte;
    next_rel_lo = reload_low_byte;
    next_rel_hi = reload_high_byte;
    next_ctrl   = ctrl;
    next_div12  = div12_tick ? 4'h0 : div12_cnt + 4'h1;
    // Software writes first, hardware events override
    if (sfr_wr) begin
      if (hit(sfr_addr, TMR3_ADDR_CTRL)) begin
        next_ctrl = sfr_wdata;
      end
      if (hit(sfr_addr, TMR3_ADDR_RELL)) begin
        next_rel_lo = sfr_wdata;
      end
      if (hit(sfr_addr, TMR3_ADDR_RELH)) begin
        next_rel_hi = sfr_wdata;
      end
      if (hit(sfr_addr, TMR3_ADDR_CNTL)) begin
        next_cnt_lo = sfr_wdata;
      end
      if (hit(sfr_addr, TMR3_ADDR_CNTH)) begin
        next_cnt_hi = sfr_wdata;
      end
    end
    // Counting with auto-reload
    if (split_mode_select) begin
      if (tick_lo) begin
        next_cnt_lo = wrap_lo ? reload_low_byte : count_low_byte + 8'h01;
      end
      if (run_control && tick_hi) begin
        next_cnt_hi = wrap_hi ? reload_high_byte : count_high_byte + 8'h01;
      end
    end else if (run_control && tick_lo) begin
      if (wrap_hi) begin
        next_cnt_lo = reload_low_byte;
        next_cnt_hi = reload_high_byte;
      end else begin
        next_cnt_lo = count_low_byte + 8'h01;
        if (wrap_lo) begin
          next_cnt_hi = count_high_byte + 8'h01;
        end
      end
    end
    // Capture overwrites reload registers
    if (capture_mode_enable && cap_trig) begin
      next_rel_lo = count_low_byte;
      next_rel_hi = count_high_byte;
      next_ctrl[TMR3_BIT_HFLAG] = 1'b1;
    end
    if (wrap_hi) begin
      next_ctrl[TMR3_BIT_HFLAG] = 1'b1;
    end
    if (wrap_lo) begin
      next_ctrl[TMR3_BIT_LFLAG] = 1'b1;
    end
  end

  // Read data mux, registered
  always_comb begin
    next_rdata = sfr_rdata;
    if (sfr_rd) begin
      next_rdata = TMR3_BYTE_RESET;
      if (hit(sfr_addr, TMR3_ADDR_CTRL)) next_rdata = ctrl;
      if (hit(sfr_addr, TMR3_ADDR_RELL)) next_rdata = reload_low_byte;
      if (hit(sfr_addr, TMR3_ADDR_RELH)) next_rdata = reload_high_byte;
      if (hit(sfr_addr, TMR3_ADDR_CNTL)) next_rdata = count_low_byte;
      if (hit(sfr_addr, TMR3_ADDR_CNTH)) next_rdata = count_high_byte;
    end
  end

  // Interrupt request from pending flags
  assign timer_irq = timer_irq_enable
                     && (ctrl[TMR3_BIT_HFLAG]
                     || (ctrl[TMR3_BIT_LIEN] && ctrl[TMR3_BIT_LFLAG]));

  // Registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl             <= TMR3_CTRL_RESET;
      count_low_byte   <= TMR3_BYTE_RESET;
      count_high_byte  <= TMR3_BYTE_RESET;
      reload_low_byte  <= TMR3_BYTE_RESET;
      reload_high_byte <= TMR3_BYTE_RESET;
      div12_cnt        <= 4'h0;
      sfr_rdata        <= TMR3_BYTE_RESET;
    end else begin
      ctrl             <= next_ctrl;
      count_low_byte   <= next_cnt_lo;
      count_high_byte  <= next_cnt_hi;
      reload_low_byte  <= next_rel_lo;
      reload_high_byte <= next_rel_hi;
      div12_cnt        <= next_div12;
      sfr_rdata        <= next_rdata;
    end
  end
endmodule
`default_nettype wire

/* testbench/tmr3_checker.sv */
// Port-level assertions for the timer 3 control block
`timescale 1ns/10ps
`default_nettype none
module tmr3_checker
  import tmr3_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [3:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       timer_irq_enable,
  input wire logic       timer_irq
);
  logic ctl_wr;
  logic ctl_rd;
  logic unmap;
  logic pg0;
  // Decoded accesses
  assign pg0 = sfr_page == TMR3_SFR_PAGE;
  assign ctl_wr = sfr_wr && pg0 && sfr_addr == TMR3_ADDR_CTRL;
  assign ctl_rd = sfr_rd && pg0 && sfr_addr == TMR3_ADDR_CTRL;
  assign unmap = !pg0 || sfr_addr < TMR3_ADDR_CTRL
                 || sfr_addr > TMR3_ADDR_CNTH;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_irq_gate;
    !timer_irq_enable |-> !timer_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq raised while disabled");
  property p_sw_set;
    ctl_wr && sfr_wdata[7] ##1 timer_irq_enable |-> timer_irq;
  endproperty
  a_sw_set: assert property (p_sw_set)
    else $error("high flag set without irq");
  property p_lien;
    ctl_wr && sfr_wdata[6:5] == 2'h3 ##1 timer_irq_enable |-> timer_irq;
  endproperty
  a_lien: assert property (p_lien)
    else $error("low flag with enable gave no irq");
  property p_sticky;
    timer_irq && timer_irq_enable && !ctl_wr |=>
      timer_irq || !timer_irq_enable;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("irq dropped without software write");
  property p_unmap;
    sfr_rd && unmap |=> sfr_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_hold;
    !sfr_rd |=> $stable(sfr_rdata);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data changed without read");
  property p_wr_rd;
    ctl_wr ##1 !sfr_wr ##1 ctl_rd && !sfr_wr |=>
      sfr_rdata[5:0] == $past(sfr_wdata[5:0], 3);
  endproperty
  a_wr_rd: assert property (p_wr_rd)
    else $error("control bits not read back");
  property p_ctl_irq;
    ctl_rd && !sfr_wr ##1 sfr_rdata[7] && timer_irq_enable |-> timer_irq;
  endproperty
  a_ctl_irq: assert property (p_ctl_irq)
    else $error("high flag read set but no irq");
endmodule
bind tmr3_timer tmr3_checker tmr3_checker_inst (
  .mclk(mclk),
  .rst_n(rst_n),
  .sfr_page(sfr_page),
  .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata),
  .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata),
  .timer_irq_enable(timer_irq_enable),
  .timer_irq(timer_irq)
);
`default_nettype wire

/* testbench/tb_tmr3_timer.sv */
// Self-checking testbench for the timer 3 control block
`timescale 1ns/10ps
`default_nettype none
module tb_tmr3_timer import tmr3_pkg::*;;
  logic       mclk = 0, rst_n = 0, wr = 0, rd = 0, irq;
  logic       hs = 1, ls = 1, ien = 1, osc = 0, cmp = 0;
  logic [3:0] page = 4'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  int         bad_count = 0, cmp_count = 0;
  tmr3_timer tmr3_timer_inst (.mclk(mclk), .rst_n(rst_n), .sfr_page(page),
    .sfr_addr(addr), .sfr_wdata(wdata), .sfr_wr(wr), .sfr_rd(rd),
    .sfr_rdata(rdata), .clk_sel_high(hs), .clk_sel_low(ls),
    .timer_irq_enable(ien), .ext_osc_in(osc), .comparator_in(cmp),
    .timer_irq(irq));
  // Clock and free-running oscillator
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk) osc <= ~osc;
  task automatic chk8(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t irq %b expected %b", $time, got, exp);
    end
  endtask
  task automatic sw(input logic [7:0] a, d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic sr(input logic [7:0] a, e);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk8(rdata, e);
  endtask
  // Full wrap from FFFF in one clock mode
  task automatic ovf(input logic [7:0] m, e, input logic s);
    @(posedge mclk);
    hs <= s;
    ls <= s;
    sw(8'h94, 8'hFF);
    sw(8'h95, 8'hFF);
    sw(8'h91, m);
    repeat (40) @(posedge mclk);
    sr(8'h91, e);
    chk1(irq, 1'b1);
    sw(8'h91, 8'h00);
    sr(8'h95, 8'h12);
    $display("overflow test done");
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (3000) @(posedge mclk);
    bad_count++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) sr(8'h90 + i[7:0], 8'h00);
    sw(8'h91, 8'h23);
    sr(8'h91, 8'h23);
    @(posedge mclk);
    page <= 4'h1;
    sw(8'h91, 8'hFF);
    sr(8'h91, 8'h00);
    @(posedge mclk);
    page <= 4'h0;
    sr(8'h91, 8'h23);
    sw(8'h90, 8'h5A);
    sr(8'h90, 8'h00);
    sw(8'h91, 8'h00);
    $display("register test done");
    sw(8'h92, 8'h34);
    sw(8'h93, 8'h12);
    ovf(8'h04, 8'hC4, 1'b1);
    ovf(8'h05, 8'hC5, 1'b0);
    ovf(8'h06, 8'hC6, 1'b0);
    // Comparator as the count clock, one rising edge every 8 cycles
    fork
      ovf(8'h07, 8'hC7, 1'b0);
      repeat (12) begin
        repeat (4) @(posedge mclk);
        cmp <= ~cmp;
      end
    join
    @(posedge mclk);
    hs <= 1'b1;
    ls <= 1'b1;
    sw(8'h94, 8'hFE);
    sw(8'h95, 8'h00);
    sw(8'h91, 8'h08);
    repeat (10) @(posedge mclk);
    sr(8'h91, 8'h48);
    sr(8'h95, 8'h00);
    sw(8'h91, 8'h68);
    @(negedge mclk);
    chk1(irq, 1'b1);
    @(posedge mclk);
    ien <= 1'b0;
    @(negedge mclk);
    chk1(irq, 1'b0);
    @(posedge mclk);
    ien <= 1'b1;
    sw(8'h91, 8'h80);
    @(negedge mclk);
    chk1(irq, 1'b1);
    sw(8'h91, 8'h00);
    sr(8'h91, 8'h00);
    chk1(irq, 1'b0);
    sw(8'h94, 8'h00);
    sw(8'h95, 8'hFE);
    sw(8'h91, 8'h0C);
    repeat (6) @(posedge mclk);
    sr(8'h91, 8'h8C);
    sw(8'h91, 8'h00);
    $display("split test done");
    sw(8'h94, 8'h00);
    sw(8'h95, 8'h00);
    sw(8'h91, 8'h14);
    repeat (4) @(posedge mclk);
    cmp <= 1'b1;
    repeat (10) @(posedge mclk);
    sr(8'h91, 8'h94);
    sr(8'h93, 8'h00);
    sr(8'h92, 8'h07);
    sw(8'h91, 8'h00);
    cmp <= 1'b0;
    $display("capture test done");
    sw(8'h94, 8'h00);
    sw(8'h95, 8'h00);
    sw(8'h91, 8'h16);
    repeat (20) @(posedge mclk);
    sr(8'h91, 8'h96);
    sr(8'h93, 8'h00);
    sw(8'h91, 8'h00);
    $display("osc capture test done");
    complete_run();
  end
endmodule
`default_nettype wire
